//--- core/adc_control_byte_interface.sv
// Notes on behaviour
// - serial input held high gives byte all ones: channel seven, external clock
// - external mode: strobe high one clock period right before result MSB
// - input tied high: one conversion every 15 serial clocks
// - strobe and data out change only on falling serial clock edges, and clear when chip select rises
// - bits 6..4 with config bit choose the analog inputs
// - bit 3 high unipolar, low bipolar
// - bit 2 high single-ended, low differential
// - single-ended negative input is the shared return
// - single-ended channel index is mid, lo, hi selection bits
// - zeros before the start bit are ignored
// - differential: lower bits pick pair, hi bit picks odd positive
// - serial input sampled on rising serial clock edges
// - conversion begins on falling edge after eighth control bit
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.svh"

module adc_control_byte_interface
  import adc_ctl_pkg::*;
(
  // system
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // serial link
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_din,
  output logic             o_dout,
  output logic             o_dout_oe,
  output logic             o_conv_strobe,
  output logic             o_conv_strobe_oe,
  // converter side
  input  wire logic [11:0] i_result,
  input  wire logic        i_result_valid,
  output logic             o_conv_start,
  output logic [2:0]       o_pos_channel,
  output logic [2:0]       o_neg_channel,
  output logic             o_neg_shared_return,
  output logic             o_unipolar,
  output logic [1:0]       o_power_clock_mode
);

  adc_link_if lnk ();

  // ------------------------------------------------------------
  // link logic: chip select high is the frame's own reset
  // ------------------------------------------------------------
  // sclk stands still outside frames, so nothing here may wait for an
  // edge after cs rises; the async clear ends the frame instead

  logic       in_active_r;
  logic [2:0] in_cnt_r;
  logic [5:0] in_sh_r;
  logic [7:0] byte_r;
  logic       req_r;
  logic       done_tgl_r;
  logic       ack_s1_r;
  logic       ack_s2_r;
  logic       gate_r;

  // ------------------------------------------------------------
  // rising edge: control byte framing
  // ------------------------------------------------------------
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      in_active_r <= 1'b0;
      in_cnt_r    <= 3'h0;
      in_sh_r     <= 6'h00;
      byte_r      <= 8'h00;
      done_tgl_r  <= 1'b0;
    end
    else if (!in_active_r)
    begin
      // zeros and bits during the early result are dropped
      if (i_din && gate_r)
      begin
        in_active_r <= 1'b1;
        in_cnt_r    <= 3'h0;
      end
    end
    else
    begin
      in_sh_r  <= {in_sh_r[4:0], i_din};
      in_cnt_r <= in_cnt_r + 3'h1;
      if (in_cnt_r == `ADC_BYTE_LAST_CNT)
      begin
        byte_r      <= {1'b1, in_sh_r, i_din};
        in_active_r <= 1'b0;
        done_tgl_r  <= ~done_tgl_r;
      end
    end
  end

  // request stays up until the core has seen it; the byte is stable
  // for at least seven clocks after that, far longer than the crossing
  always_ff @(posedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      req_r    <= 1'b0;
    end
    else
    begin
      ack_s1_r <= lnk.ack;
      ack_s2_r <= ack_s1_r;
      if (in_active_r && in_cnt_r == `ADC_BYTE_LAST_CNT)
        req_r <= 1'b1;
      else if (ack_s2_r)
        req_r <= 1'b0;
    end
  end

  assign lnk.req      = req_r;
  assign lnk.ctl_byte = byte_r;

  // ------------------------------------------------------------
  // falling edge: strobe and result shifting
  // ------------------------------------------------------------
  out_state_t  st_r;
  logic        seen_tgl_r;
  logic        int_mode_r;
  logic        busy_s1_r;
  logic        busy_s2_r;
  logic        busy_seen_r;
  logic [3:0]  out_cnt_r;
  logic [11:0] out_sh_r;
  logic        start;

  assign start = (done_tgl_r != seen_tgl_r);

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      busy_s1_r <= 1'b0;
      busy_s2_r <= 1'b0;
    end
    else
    begin
      busy_s1_r <= lnk.busy;
      busy_s2_r <= busy_s1_r;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      st_r          <= OUT_IDLE;
      seen_tgl_r    <= 1'b0;
      int_mode_r    <= 1'b0;
      busy_seen_r   <= 1'b0;
      out_cnt_r     <= 4'h0;
      out_sh_r      <= 12'h000;
      gate_r        <= 1'b1;
      o_conv_strobe <= 1'b0;
      o_dout        <= 1'b0;
    end
    else if (start)
    begin
      // a new byte aborts whatever result is still leaving
      seen_tgl_r  <= done_tgl_r;
      gate_r      <= 1'b0;
      busy_seen_r <= 1'b0;
      o_dout      <= 1'b0;
      int_mode_r  <= (byte_r[`ADC_BIT_MODE_HI:`ADC_BIT_MODE_LO] == `ADC_MODE_INT_CLK);
      if (byte_r[`ADC_BIT_MODE_HI:`ADC_BIT_MODE_LO] == `ADC_MODE_INT_CLK)
      begin
        o_conv_strobe <= 1'b0;
        st_r          <= OUT_WAIT_INT;
      end
      else
      begin
        o_conv_strobe <= 1'b1;
        st_r          <= OUT_STROBE;
      end
    end
    else
    begin
      case (st_r)
        OUT_IDLE:
        begin
          o_dout        <= 1'b0;
          o_conv_strobe <= 1'b0;
          gate_r        <= 1'b1;
        end
        OUT_WAIT_INT:
        begin
          if (busy_s2_r)
            busy_seen_r <= 1'b1;
          else if (busy_seen_r)
          begin
            o_conv_strobe <= 1'b1;
            st_r          <= OUT_STROBE;
          end
        end
        OUT_STROBE:
        begin
          // mailbox word is quiet here: the core updated it long before
          o_conv_strobe <= int_mode_r;
          o_dout        <= lnk.res_word[`ADC_RESULT_BITS-1];
          out_sh_r      <= {lnk.res_word[`ADC_RESULT_BITS-2:0], 1'b0};
          out_cnt_r     <= 4'h1;
          st_r          <= OUT_SHIFT;
        end
        OUT_SHIFT:
        begin
          if (out_cnt_r == `ADC_LAST_OUT_CNT)
          begin
            o_dout <= 1'b0;
            st_r   <= OUT_IDLE;
          end
          else
          begin
            o_dout    <= out_sh_r[`ADC_RESULT_BITS-1];
            out_sh_r  <= {out_sh_r[`ADC_RESULT_BITS-2:0], 1'b0};
            out_cnt_r <= out_cnt_r + 4'h1;
          end
          // next start bit is taken once result bit 5 is out
          if (out_cnt_r == `ADC_REOPEN_CNT)
            gate_r <= 1'b1;
        end
        default:
        begin
          st_r <= OUT_IDLE;
        end
      endcase
    end
  end

  assign o_dout_oe        = ~i_cs_n;
  assign o_conv_strobe_oe = ~i_cs_n;

  // ------------------------------------------------------------
  // system clock side
  // ------------------------------------------------------------
  adc_conv_core u_core (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .lnk                 (lnk.core),
    .i_result            (i_result),
    .i_result_valid      (i_result_valid),
    .o_conv_start        (o_conv_start),
    .o_pos_channel       (o_pos_channel),
    .o_neg_channel       (o_neg_channel),
    .o_neg_shared_return (o_neg_shared_return),
    .o_unipolar          (o_unipolar),
    .o_power_clock_mode  (o_power_clock_mode)
  );

endmodule : adc_control_byte_interface

`default_nettype wire

//--- core/adc_conv_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctl_consts.svh"

module adc_conv_core
  import adc_ctl_pkg::*;
(
  // system
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // link side
  adc_link_if.core         lnk,
  // converter side
  input  wire logic [11:0] i_result,
  input  wire logic        i_result_valid,
  output logic             o_conv_start,
  output logic [2:0]       o_pos_channel,
  output logic [2:0]       o_neg_channel,
  output logic             o_neg_shared_return,
  output logic             o_unipolar,
  output logic [1:0]       o_power_clock_mode
);

  // ------------------------------------------------------------
  // channel decode
  // ------------------------------------------------------------
  function automatic logic [5:0] pick_pair(input logic [7:0] b);
    logic [1:0] pair;
    logic       hi;
    pair = {b[`ADC_BIT_PICK_MID], b[`ADC_BIT_PICK_LO]};
    hi   = b[`ADC_BIT_PICK_HI];
    if (b[`ADC_BIT_CONFIG])
      // single-ended: index is mid, lo, hi
      pick_pair = {pair, hi, 3'h0};
    else
      // differential: even channel positive unless hi set
      pick_pair = {pair, hi, pair, ~hi};
  endfunction : pick_pair

  // ------------------------------------------------------------
  // request crossing
  // ------------------------------------------------------------
  logic       req_s1_r;
  logic       req_s2_r;
  logic       req_s3_r;
  logic       take;
  logic [5:0] pp;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
    end
    else
    begin
      req_s1_r <= lnk.req;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  assign take    = req_s2_r & ~req_s3_r;
  assign lnk.ack = req_s2_r;
  assign pp      = pick_pair(lnk.ctl_byte);

  // ------------------------------------------------------------
  // decoded controls, held until the next byte
  // ------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_conv_start        <= 1'b0;
      o_pos_channel       <= `ADC_RESET_POS_CH;
      o_neg_channel       <= 3'h0;
      o_neg_shared_return <= 1'b1;
      o_unipolar          <= 1'b1;
      o_power_clock_mode  <= `ADC_MODE_EXT_CLK;
    end
    else
    begin
      o_conv_start <= take;
      if (take)
      begin
        o_pos_channel       <= pp[5:3];
        o_neg_channel       <= pp[2:0];
        o_neg_shared_return <= lnk.ctl_byte[`ADC_BIT_CONFIG];
        o_unipolar          <= lnk.ctl_byte[`ADC_BIT_POLARITY];
        o_power_clock_mode  <= lnk.ctl_byte[`ADC_BIT_MODE_HI:`ADC_BIT_MODE_LO];
      end
    end
  end

  // ------------------------------------------------------------
  // result mailbox; a new start wins over a finishing result
  // ------------------------------------------------------------
  logic        busy_r;
  logic [11:0] res_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      busy_r <= 1'b0;
    else if (take)
      busy_r <= 1'b1;
    else if (i_result_valid)
      busy_r <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      res_r <= 12'h000;
    else if (i_result_valid)
      res_r <= i_result;
  end

  assign lnk.busy     = busy_r;
  assign lnk.res_word = res_r;

endmodule : adc_conv_core

`default_nettype wire

//--- core/adc_ctl_consts.svh
`ifndef ADC_CTL_CONSTS_SVH
`define ADC_CTL_CONSTS_SVH

// ------------------------------------------------------------
// control byte layout
// ------------------------------------------------------------
`define ADC_BIT_START      7
`define ADC_BIT_PICK_HI    6
`define ADC_BIT_PICK_MID   5
`define ADC_BIT_PICK_LO    4
`define ADC_BIT_POLARITY   3
`define ADC_BIT_CONFIG     2
`define ADC_BIT_MODE_HI    1
`define ADC_BIT_MODE_LO    0

// ------------------------------------------------------------
// mode codes and sizes
// ------------------------------------------------------------
`define ADC_MODE_FULL_PD   2'h0
`define ADC_MODE_FAST_PD   2'h1
`define ADC_MODE_INT_CLK   2'h2
`define ADC_MODE_EXT_CLK   2'h3
`define ADC_RESULT_BITS    12
`define ADC_BYTE_LAST_CNT  3'h6
`define ADC_REOPEN_CNT     4'h6
`define ADC_RESET_POS_CH   3'h7
`define ADC_LAST_OUT_CNT   4'hC

`endif

//--- core/adc_ctl_pkg.sv
package adc_ctl_pkg;

  typedef enum logic [1:0] {
    MODE_FULL_PD,
    MODE_FAST_PD,
    MODE_INT_CLK,
    MODE_EXT_CLK
  } mode_t;

  typedef enum {
    OUT_IDLE,
    OUT_STROBE,
    OUT_SHIFT,
    OUT_WAIT_INT
  } out_state_t;

endpackage : adc_ctl_pkg

//--- core/adc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
  logic        req;
  logic [7:0]  ctl_byte;
  logic        ack;
  logic        busy;
  logic [11:0] res_word;

  modport link (output req, output ctl_byte, input ack, input busy, input res_word);
  modport core (input req, input ctl_byte, output ack, output busy, output res_word);
endinterface : adc_link_if

`default_nettype wire

//--- test/adc_cbi_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_cbi_chk (
  // watched ports
  input wire logic       i_clk,
  input wire logic       i_rst_n,
  input wire logic       i_sclk,
  input wire logic       i_cs_n,
  input wire logic       o_dout,
  input wire logic       o_dout_oe,
  input wire logic       o_conv_strobe,
  input wire logic       o_conv_strobe_oe,
  input wire logic       o_conv_start,
  input wire logic [2:0] o_pos_channel,
  input wire logic [2:0] o_neg_channel,
  input wire logic       o_neg_shared_return,
  input wire logic [1:0] o_power_clock_mode
);
  // ----
  // helpers
  // ----
  logic [1:0] up_r;
  // value just before a rising edge must still stand at the next falling edge
  always_ff @(posedge i_sclk) up_r <= {o_dout, o_conv_strobe};
  sequence res_tail;
    ##12 !o_dout;
  endsequence
  start_gap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_conv_start |=> !o_conv_start [*8]) else $error("starts too close");
  decode_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$stable({o_pos_channel, o_neg_channel}) |-> o_conv_start) else $error("decode moved");
  se_return_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_neg_shared_return |-> o_neg_channel == 3'h0) else $error("bad return");
  diff_pair_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_neg_shared_return |-> o_pos_channel[2:1] == o_neg_channel[2:1]
    && o_pos_channel[0] != o_neg_channel[0]) else $error("bad pair");
  oe_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_dout_oe == !i_cs_n && o_conv_strobe_oe == !i_cs_n
    && (!i_cs_n || (!o_dout && !o_conv_strobe))) else $error("bad enable");
  strobe_one_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
    $rose(o_conv_strobe) |=> !o_conv_strobe || o_power_clock_mode == 2'h2)
    else $error("strobe too long");
  edge_only_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
    {o_dout, o_conv_strobe} == up_r) else $error("output moved on rising");
  result_len_a: assert property (@(negedge i_sclk) disable iff (i_cs_n)
    $fell(o_conv_strobe) |-> res_tail) else $error("result too long");
endmodule : adc_cbi_chk
bind adc_control_byte_interface adc_cbi_chk chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_sclk(i_sclk), .i_cs_n(i_cs_n), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
  .o_conv_strobe(o_conv_strobe), .o_conv_strobe_oe(o_conv_strobe_oe),
  .o_conv_start(o_conv_start), .o_pos_channel(o_pos_channel),
  .o_neg_channel(o_neg_channel), .o_neg_shared_return(o_neg_shared_return),
  .o_power_clock_mode(o_power_clock_mode));
`default_nettype wire

//--- test/adc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  // serial master
  output logic       o_sclk,
  output logic       o_cs_n,
  output logic       o_din,
  input  wire logic  i_dout,
  input  wire logic  i_strobe
);
  logic [31:0] rx_d;
  logic [31:0] rx_s;
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din  = 1'b0;
  end
  // sclk stands still between frames; odd start offset keeps phase unrelated
  task automatic frame(input logic [31:0] pat, input int n);
    int k;
    rx_d = 32'h0;
    rx_s = 32'h0;
    #1.3 o_cs_n = 1'b0;
    for (k = 0; k < n; k++)
    begin
      o_din = pat[31-k];
      #3 o_sclk = 1'b1;
      rx_d[31-k] = i_dout;
      rx_s[31-k] = i_strobe;
      #3 o_sclk = 1'b0;
    end
    #3 o_cs_n = 1'b1;
    o_din = ~o_din;
  endtask : frame
endmodule : adc_host_model
`default_nettype wire

//--- test/test_adc_control_byte_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_control_byte_interface
  import adc_ctl_pkg::*;
;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_result_valid = 1'b0;
  logic [11:0] i_result = 12'h0;
  logic        i_sclk, i_cs_n, i_din, o_dout, o_dout_oe, o_conv_strobe, o_conv_strobe_oe;
  logic        o_conv_start, o_neg_shared_return, o_unipolar, dout_w, strobe_w;
  logic [2:0]  o_pos_channel, o_neg_channel;
  logic [1:0]  o_power_clock_mode;
  int          num_errors = 0, samples_checked = 0, starts = 0, cycles = 0, s0, i;
  // released pins toggle so a stale value cannot pass
  assign dout_w   = o_dout_oe ? o_dout : cycles[0];
  assign strobe_w = o_conv_strobe_oe ? o_conv_strobe : ~cycles[0];
  always #5 i_clk = ~i_clk;
  adc_control_byte_interface dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
    .i_cs_n(i_cs_n), .i_din(i_din), .o_dout(o_dout), .o_dout_oe(o_dout_oe),
    .o_conv_strobe(o_conv_strobe), .o_conv_strobe_oe(o_conv_strobe_oe),
    .i_result(i_result), .i_result_valid(i_result_valid), .o_conv_start(o_conv_start),
    .o_pos_channel(o_pos_channel), .o_neg_channel(o_neg_channel),
    .o_neg_shared_return(o_neg_shared_return), .o_unipolar(o_unipolar),
    .o_power_clock_mode(o_power_clock_mode));
  adc_host_model host_u (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_din(i_din),
    .i_dout(dout_w), .i_strobe(strobe_w));
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  always @(posedge i_clk)
  begin
    cycles++;
    if (o_conv_start === 1'b1)
      starts++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // the mailbox must hold the word before the conversion reads it
  task automatic put_res(input logic [11:0] r);
    @(posedge i_clk);
    i_result <= r;
    i_result_valid <= 1'b1;
    @(posedge i_clk);
    i_result_valid <= 1'b0;
  endtask : put_res
  task automatic dec_chk(input logic [7:0] b);
    repeat (8) @(posedge i_clk);
    chk("pos", 12'({b[5], b[4], b[6]}), 12'(o_pos_channel));
    chk("neg", b[2] ? 12'h0 : 12'({b[5], b[4], ~b[6]}), 12'(o_neg_channel));
    chk("ret", 12'(b[2]), 12'(o_neg_shared_return));
    chk("uni", 12'(b[3]), 12'(o_unipolar));
    chk("mode", 12'(b[1:0]), 12'(o_power_clock_mode));
  endtask : dec_chk
  task automatic byte_chk(input logic [7:0] b, input logic [11:0] r);
    put_res(r);
    s0 = starts;
    host_u.frame({3'h0, b, 21'h0}, 32);
    dec_chk(b);
    chk("starts", 12'h1, 12'(starts - s0));
    chk("stb", 12'(b[1:0] != 2'h2), host_u.rx_s[31:20]);
    chk("stb_tail", 12'h0, host_u.rx_s[19:8]);
    if (b[1:0] != 2'h2)
      chk("res", r, host_u.rx_d[19:8]);
  endtask : byte_chk
  // internal clock: strobe waits for the converter result, then the word follows
  task automatic int_chk(input logic [7:0] b);
    put_res(12'h000);
    s0 = starts;
    fork
      host_u.frame({b, 24'h0}, 32);
      begin
        repeat (10) @(posedge i_clk);
        put_res(12'hFFF);
      end
    join
    chk("starts", 12'h1, 12'(starts - s0));
    chk("int_wait", 12'h000, host_u.rx_s[31:20]);
    chk("int_stb", 12'h00F, 12'(host_u.rx_s[3:0]));
    chk("int_res", 12'h00F, 12'(host_u.rx_d[3:0]));
    dec_chk(b);
  endtask : int_chk
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    put_res(12'hA5C);
    s0 = starts;
    host_u.frame(32'hFFFFFFFF, 32);
    dec_chk(8'hFF);
    chk("starts", 12'h2, 12'(starts - s0));
    chk("stb_a", 12'h800, host_u.rx_s[23:12]);
    chk("stb_b", 12'h100, host_u.rx_s[11:0]);
    chk("res", 12'hA5C, host_u.rx_d[22:11]);
    chk("tail", 12'h0, 12'(host_u.rx_d[10:9]));
    for (i = 0; i < 16; i++)
      byte_chk({1'b1, i[2:0], i[0] ^ i[3], i[3], (i % 3 == 2) ? 2'h3 : 2'(i % 3)},
               12'(i * 273 + 5));
    s0 = starts;
    host_u.frame(32'h0, 32);
    chk("no_start", 12'h0, 12'(starts - s0));
    host_u.frame(32'hB0000000, 4);
    byte_chk(8'h87, 12'h3C1);
    byte_chk(8'hF6, 12'h0F0);
    int_chk(8'hAA);
    end_sim();
  end
endmodule : test_adc_control_byte_interface
`default_nettype wire
